// [voice_store_regs.vh]
// Purpose: shared constants of the voice store host port
// Assumes: core clock of 100 MHz
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef VOICE_STORE_REGS_VH
`define VOICE_STORE_REGS_VH

`define CORE_CLK_HZ        100000000
`define INT_SAMPLE_HZ      6400
// core clock over internal sample rate, sized so the divider parameter takes it whole
`define INT_SAMPLE_CYCLES  16'h3d09
`define EXT_LOSS_NS        10000
`define EXT_LOSS_CYCLES    ((`EXT_LOSS_NS * 100) / 1000)
`define FRAME_BITS         16
`define BIT_CNT_W          5
`define SEG_SAMPLES        256
`define SYNC_W             4
`define SYNC_SCLK          0
`define SYNC_CS            1
`define SYNC_SDI           2
`define SYNC_EXT           3
`define STAT_WARN          15
`define STAT_INT           14
`define STAT_HELD          13
`define STAT_EXT           12
`define STAT_RUN           11

`endif

// [pin_sync.v]
// Purpose: two-stage synchroniser for a group of pins
// Assumes: pins are asynchronous to core_clk
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
`include "voice_store_regs.vh"

module pin_sync (
	input  wire                 core_clk,
	input  wire                 resetn,
	input  wire [`SYNC_W-1:0]   pins,
	output wire [`SYNC_W-1:0]   pins_sync
);
	reg [`SYNC_W-1:0] stage1;
	reg [`SYNC_W-1:0] stage2;

	genvar i;
	generate
		for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
			// cs idles high, others idle low, so the reset value matches an idle bus
			always @(posedge core_clk) begin
				if (!resetn) begin
					stage1[i] <= (i == `SYNC_CS) ? 1'b1 : 1'b0;
					stage2[i] <= (i == `SYNC_CS) ? 1'b1 : 1'b0;
				end else begin
					stage1[i] <= pins[i];
					stage2[i] <= stage1[i];
				end
			end
		end
	endgenerate

	assign pins_sync = stage2;
endmodule // pin_sync
`default_nettype wire

// [voice_store_host_port.v]
// Purpose: host-facing serial port, segment warning and interrupt of a voice store
// Assumes: host is a serial master; link pins are sampled by core_clk (sclk far below 50 MHz)
// Notes:   opcodes are decoded downstream; this block frames, queues and signals
// Overview of operation
// - serial_in is sampled on each of the first 16 rising serial clock edges while selected.
// - serial_out changes on each falling serial clock edge.
// - low chip select makes this device the active slave; host drives it low.
// - with chip select high the output floats and serial_in is ignored.
// - segment_end_warn_n low signals the active segment is nearly used up.
// - interrupt pulled low on message end or overflow, otherwise released; the code holds it low until chip select next falls.
// - an external sample clock replaces the internal sampling clock.
// - reset clears address counters and restores all settings to defaults.
// - warning falls at half segment, returns high when the segment is full.
// - command during warning low is taken; later ones wait for next warning.
// - interrupt also raised after a power-up command when supply is low.
// - external clock chosen automatically when present, else internal oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "voice_store_regs.vh"

module voice_store_host_port #(
	parameter [15:0] INT_DIV = `INT_SAMPLE_CYCLES
) (
	input  wire                     core_clk,
	input  wire                     resetn,
	input  wire                     sclk,
	input  wire                     cs_n,
	input  wire                     serial_in,
	output reg                      serial_out,
	output reg                      serial_out_oe_n,
	output reg                      segment_end_warn_n,
	output wire                     irq_n_out,
	output reg                      irq_n_oe_n,
	input  wire                     ext_sample_clk,
	input  wire                     seg_run,
	input  wire                     end_of_message,
	input  wire                     overflow,
	input  wire                     power_up_command,
	input  wire                     low_supply,
	output reg                      sample_tick,
	output reg                      ext_clk_active,
	output reg                      cmd_valid,
	output reg [`FRAME_BITS-1:0]    cmd_data,
	output reg                      seg_done
);
	localparam integer EXT_LOSS_I  = `EXT_LOSS_CYCLES;
	localparam integer SEG_LEN_I   = `SEG_SAMPLES;
	localparam integer SEG_HALF_I  = `SEG_SAMPLES / 2;
	localparam integer FRAME_LEN_I = `FRAME_BITS;
	localparam [15:0] EXT_LOSS = EXT_LOSS_I[15:0];
	localparam [15:0] SEG_LEN  = SEG_LEN_I[15:0];
	localparam [15:0] SEG_HALF = SEG_HALF_I[15:0];
	localparam [`BIT_CNT_W-1:0] FRAME_LEN = FRAME_LEN_I[`BIT_CNT_W-1:0];

	wire [`SYNC_W-1:0] pins_sync;

	pin_sync u_sync (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.pins      ({ext_sample_clk, serial_in, cs_n, sclk}),
		.pins_sync (pins_sync)
	);

	wire sclk_s = pins_sync[`SYNC_SCLK];
	wire cs_s   = pins_sync[`SYNC_CS];
	wire sdi_s  = pins_sync[`SYNC_SDI];
	wire ext_s  = pins_sync[`SYNC_EXT];

	reg sclk_d;
	reg cs_d;
	reg ext_d;
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire cs_fall   = ~cs_s & cs_d;
	wire cs_rise   = cs_s & ~cs_d;
	wire ext_rise  = ext_s & ~ext_d;

	// serial link
	reg [`FRAME_BITS-1:0] rx_shift;
	reg [`FRAME_BITS-1:0] tx_shift;
	reg [`BIT_CNT_W-1:0]  bit_cnt;
	reg                   frame_done;
	reg [15:0]            seg_cnt;
	reg                   held;
	reg [`FRAME_BITS-1:0] held_data;
	reg                   irq_pend;

	wire [`FRAME_BITS-1:0] status_word = {segment_end_warn_n, irq_pend, held, ext_clk_active,
		seg_run, 11'h000};

	always @(posedge core_clk) begin
		if (!resetn) begin
			sclk_d          <= 1'b0;
			cs_d            <= 1'b1;
			ext_d           <= 1'b0;
			rx_shift        <= 16'h0000;
			tx_shift        <= 16'h0000;
			bit_cnt         <= 5'h00;
			serial_out      <= 1'b0;
			serial_out_oe_n <= 1'b1;
			frame_done      <= 1'b0;
		end else begin
			sclk_d     <= sclk_s;
			cs_d       <= cs_s;
			ext_d      <= ext_s;
			frame_done <= 1'b0;
			serial_out_oe_n <= cs_s;
			if (cs_s) begin
				bit_cnt <= 5'h00;
			end else if (cs_fall) begin
				tx_shift   <= {status_word[`FRAME_BITS-2:0], 1'b0};
				serial_out <= status_word[`FRAME_BITS-1];
				bit_cnt    <= 5'h00;
			end else begin
				if (sclk_rise && bit_cnt != FRAME_LEN) begin
					rx_shift <= {rx_shift[`FRAME_BITS-2:0], sdi_s};
					bit_cnt  <= bit_cnt + 5'h01;
				end
				if (sclk_fall) begin
					serial_out <= tx_shift[`FRAME_BITS-1];
					tx_shift   <= {tx_shift[`FRAME_BITS-2:0], 1'b0};
				end
			end
			// a frame counts only when chip select closes a whole word
			if (cs_rise && bit_cnt == FRAME_LEN) begin
				frame_done <= 1'b1;
			end
		end
	end

	// sample clock source
	reg [15:0] ext_watch;
	reg [15:0] int_div;

	always @(posedge core_clk) begin
		if (!resetn) begin
			ext_watch      <= 16'h0000;
			ext_clk_active <= 1'b0;
			int_div        <= 16'h0000;
			sample_tick    <= 1'b0;
		end else begin
			if (ext_rise) begin
				ext_watch <= EXT_LOSS;
			end else if (ext_watch != 16'h0000) begin
				ext_watch <= ext_watch - 16'h0001;
			end
			ext_clk_active <= (ext_watch != 16'h0000);
			if (int_div >= INT_DIV - 16'h0001) begin
				int_div <= 16'h0000;
			end else begin
				int_div <= int_div + 16'h0001;
			end
			// the internal oscillator keeps running so fallback needs no restart
			if (ext_clk_active) begin
				sample_tick <= ext_rise;
			end else begin
				sample_tick <= (int_div == 16'h0000);
			end
		end
	end

	// segment progress and command queue
	wire at_half = (seg_cnt == SEG_HALF - 16'h0001);
	wire at_end  = (seg_cnt == SEG_LEN - 16'h0001);

	always @(posedge core_clk) begin
		if (!resetn) begin
			seg_cnt            <= 16'h0000;
			segment_end_warn_n <= 1'b1;
			seg_done           <= 1'b0;
			held               <= 1'b0;
			held_data          <= 16'h0000;
			cmd_valid          <= 1'b0;
			cmd_data           <= 16'h0000;
		end else begin
			seg_done  <= 1'b0;
			cmd_valid <= 1'b0;
			if (!seg_run) begin
				seg_cnt            <= 16'h0000;
				segment_end_warn_n <= 1'b1;
			end else if (sample_tick) begin
				if (at_end) begin
					seg_cnt            <= 16'h0000;
					segment_end_warn_n <= 1'b1;
					seg_done           <= 1'b1;
				end else begin
					seg_cnt <= seg_cnt + 16'h0001;
					if (at_half) begin
						segment_end_warn_n <= 1'b0;
					end
				end
			end
			if (frame_done) begin
				if (!seg_run || !segment_end_warn_n) begin
					cmd_valid <= 1'b1;
					cmd_data  <= rx_shift;
					// a newer command supersedes a waiting one, so an older word never follows it
					held      <= 1'b0;
				end else begin
					// only the latest waiting command is kept
					held      <= 1'b1;
					held_data <= rx_shift;
				end
			end else if (held && (!seg_run || !segment_end_warn_n)) begin
				held      <= 1'b0;
				cmd_valid <= 1'b1;
				cmd_data  <= held_data;
			end
		end
	end

	// interrupt: held until the host opens the next transfer; a new event wins
	always @(posedge core_clk) begin
		if (!resetn) begin
			irq_pend   <= 1'b0;
			irq_n_oe_n <= 1'b1;
		end else begin
			if (end_of_message || overflow || (power_up_command && low_supply)) begin
				irq_pend <= 1'b1;
			end else if (cs_fall) begin
				irq_pend <= 1'b0;
			end
			irq_n_oe_n <= ~irq_pend;
		end
	end

	assign irq_n_out = 1'b0;
endmodule // voice_store_host_port
`default_nettype wire

// [vshp_sva.sv]
// Purpose: port assertions for the voice store host port
// Assumes: bound to voice_store_host_port
// Notes: three cycles of pin sync allowed for
`timescale 1ns/1ps
`default_nettype none
module vshp_sva (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic serial_out_oe_n,
	input wire logic segment_end_warn_n,
	input wire logic irq_n_out,
	input wire logic irq_n_oe_n,
	input wire logic seg_run,
	input wire logic end_of_message,
	input wire logic overflow,
	input wire logic power_up_command,
	input wire logic low_supply,
	input wire logic cmd_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_sel;
		$fell(cs_n) ##1 (!cs_n)[*5];
	endsequence
	sequence s_evt;
		end_of_message || overflow;
	endsequence
	chk_idle_reset: assert property (disable iff (1'b0) !resetn |=> segment_end_warn_n && irq_n_oe_n)
		else $error("outputs not idle after reset");
	chk_oe_off: assert property ((cs_n)[*4] |-> serial_out_oe_n)
		else $error("output driven while deselected");
	chk_oe_on: assert property (s_sel |-> !serial_out_oe_n)
		else $error("output not driven while selected");
	chk_irq_set: assert property (s_evt |-> ##2 !irq_n_oe_n)
		else $error("interrupt not pulled");
	chk_irq_power: assert property (power_up_command && low_supply |-> ##2 !irq_n_oe_n)
		else $error("low supply interrupt missing");
	chk_irq_cause: assert property ($fell(irq_n_oe_n) |->
		$past(end_of_message || overflow || (power_up_command && low_supply), 2))
		else $error("interrupt without cause");
	chk_irq_drain: assert property (irq_n_out == 1'b0)
		else $error("open drain level not low");
	chk_warn_stop: assert property (!seg_run |=> segment_end_warn_n)
		else $error("warning low while idle");
	chk_cmd_gate: assert property (cmd_valid |->
		!seg_run || !$past(seg_run) || !segment_end_warn_n || !$past(segment_end_warn_n))
		else $error("command taken outside warning");
endmodule // vshp_sva
`default_nettype wire

// [host_master.sv]
// Purpose: serial host model, mode 0, msb first
// Assumes: 125 ns link clock
// Notes: link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module host_master (
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe_n
);
	logic [15:0] rx = 16'h0000;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int n);
		cs_n = 1'b0;
		// small skew keeps every link edge after the chip select fall off the core clock edges
		#1;
		for (int i = 15; i > 15 - n; i--) begin
			serial_in = w[i];
			#62.5 sclk = 1'b1;
			rx[i] = serial_out_oe_n ? 1'bx : serial_out;
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		// released data line must not look held
		serial_in = ~serial_in;
	endtask
endmodule // host_master
`default_nettype wire

// [voice_store_host_port_test.sv]
// Purpose: self-checking bench for the voice store host port
// Assumes: internal divide shortened to 20 cycles
// Notes: link traffic comes from host_master
`timescale 1ns/1ps
`default_nettype none
module voice_store_host_port_test;
	logic core_clk = 0, resetn = 0, ext_sample_clk = 0, seg_run = 0, hit = 0;
	logic end_of_message = 0, overflow = 0, power_up_command = 0, low_supply = 0;
	wire  sclk, cs_n, serial_in, serial_out, serial_out_oe_n, segment_end_warn_n, irq_n_out, irq_n_oe_n;
	wire  sample_tick, ext_clk_active, cmd_valid, seg_done;
	wire  [15:0] cmd_data;
	int   err_total = 0, checks = 0, ticks = 0, cyc = 0;
	voice_store_host_port #(.INT_DIV(16'h0014)) uut (.core_clk(core_clk), .resetn(resetn), .sclk(sclk),
		.cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
		.segment_end_warn_n(segment_end_warn_n), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
		.ext_sample_clk(ext_sample_clk), .seg_run(seg_run), .end_of_message(end_of_message),
		.overflow(overflow), .power_up_command(power_up_command), .low_supply(low_supply),
		.sample_tick(sample_tick), .ext_clk_active(ext_clk_active), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .seg_done(seg_done));
	host_master hm (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (sample_tick === 1'b1) ticks <= ticks + 1;
		if (cyc == 32'h0000_7530) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_cmd(input int lim);
		hit = 0;
		repeat (lim) begin
			@(negedge core_clk);
			if (cmd_valid === 1'b1) hit = 1;
		end
	endtask
	task automatic wait_warn(input logic v);
		repeat (4000) if (segment_end_warn_n !== v) @(negedge core_clk);
		chk("warn", v, segment_end_warn_n);
	endtask
	task automatic t_frame;
		hm.xfer(16'ha5c3, 16);
		wait_cmd(20);
		chk("cmd_valid", 1, hit);
		chk("cmd_data", 16'ha5c3, cmd_data);
		chk("status", 16'h8000, hm.rx);
		hm.xfer(16'hffff, 8);
		wait_cmd(30);
		chk("short", 0, hit);
		$display("test frame done");
	endtask
	task automatic t_irq;
		low_supply = 1;
		for (int i = 0; i < 3; i++) begin
			{power_up_command, overflow, end_of_message} = 3'b001 << i;
			@(negedge core_clk);
			{power_up_command, overflow, end_of_message} = 3'b000;
			repeat (3) @(negedge core_clk);
			chk("irq low", 0, irq_n_oe_n);
			hm.xfer(16'h0000, 16);
			chk("irq status", 16'hc000, hm.rx);
			wait_cmd(10);
			chk("irq free", 1, irq_n_oe_n);
		end
		low_supply = 0;
		$display("test irq done");
	endtask
	task automatic t_seg;
		seg_run = 1;
		ticks = 0;
		wait_warn(0);
		chk("half", 16'h0080, ticks);
		hm.xfer(16'h1234, 16);
		wait_cmd(10);
		chk("taken", 1, hit);
		chk("taken data", 16'h1234, cmd_data);
		wait_warn(1);
		chk("full", 16'h0100, ticks);
		chk("seg done", 1, seg_done);
		hm.xfer(16'h5678, 16);
		chk("run status", 16'h8800, hm.rx);
		wait_cmd(10);
		chk("held", 0, hit);
		wait_warn(0);
		wait_cmd(3);
		chk("released", 1, hit);
		chk("released data", 16'h5678, cmd_data);
		seg_run = 0;
		$display("test segment done");
	endtask
	task automatic t_ext;
		for (int i = 0; i < 40; i++) begin
			// a rate apart from the internal divide, so the tick count tells the sources apart
			repeat (7) @(negedge core_clk);
			if (i == 4) ticks = 0;
			ext_sample_clk = ~ext_sample_clk;
		end
		repeat (10) @(negedge core_clk);
		chk("ext on", 1, ext_clk_active);
		chk("ext ticks", 16'h0012, ticks);
		repeat (1100) @(negedge core_clk);
		chk("ext off", 0, ext_clk_active);
		$display("test ext done");
	endtask
	task automatic t_reset;
		seg_run = 1;
		wait_warn(0);
		resetn = 0;
		repeat (2) @(negedge core_clk);
		chk("warn rst", 1, segment_end_warn_n);
		chk("oe rst", 1, serial_out_oe_n);
		resetn = 1;
		ticks = 0;
		wait_warn(0);
		chk("rst count", 16'h0080, ticks);
		seg_run = 0;
		$display("test reset done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge core_clk);
		resetn = 1;
		chk("warn idle", 1, segment_end_warn_n);
		chk("irq idle", 1, irq_n_oe_n);
		t_frame();
		t_irq();
		t_seg();
		t_ext();
		t_reset();
		end_of_test();
	end
endmodule // voice_store_host_port_test
bind voice_store_host_port vshp_sva chk (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n),
	.serial_out_oe_n(serial_out_oe_n), .segment_end_warn_n(segment_end_warn_n), .irq_n_out(irq_n_out),
	.irq_n_oe_n(irq_n_oe_n), .seg_run(seg_run), .end_of_message(end_of_message), .overflow(overflow),
	.power_up_command(power_up_command), .low_supply(low_supply), .cmd_valid(cmd_valid));
`default_nettype wire
